// >>> inc/hfo_pkg.sv
// Shared constants, types and decoders for the high-frequency oscillator control block
package hfo_pkg;

    // Register addresses in the special-function register space
    localparam logic [7:0] HFO_CTRL_ADDR = 8'hb2;
    localparam logic [7:0] HFO_TRIM_ADDR = 8'hb3;

    // Control and trim register bit positions
    localparam int HFO_EN_BIT = 7;
    localparam int HFO_RDY_BIT = 6;
    localparam int HFO_SUSP_BIT = 5;
    localparam int HFO_SYNC_BIT = 4;
    localparam int HFO_DIV_LSB = 0;
    localparam int HFO_TRIM_LSB = 0;

    // Values after reset, and the slowest trim code
    localparam logic HFO_EN_RESET = 1'b1;
    localparam logic HFO_RDY_RESET = 1'b1;
    localparam logic [1:0] HFO_DIV_RESET = 2'h0;
    localparam logic [6:0] HFO_TRIM_RESET = 7'h40;
    localparam logic [6:0] HFO_TRIM_SLOWEST = 7'h7f;

    // System clock source codes as seen from the clock-select register
    localparam logic [2:0] HFO_SRC_DIV = 3'h0;
    localparam logic [2:0] HFO_SRC_DIRECT = 3'h3;

    // Timing: reference clock period and oscillator settle time
    localparam int HFO_CLK_PERIOD_NS = 50;
    localparam int HFO_SETTLE_NS = 500;
    localparam int HFO_SETTLE_CYC = (HFO_SETTLE_NS + HFO_CLK_PERIOD_NS - 1) / HFO_CLK_PERIOD_NS;
    localparam int HFO_SYNC_TIMER_CLKS = 3;

    // Oscillator state, Gray coded along run -> suspend -> settle -> off
    typedef enum logic [1:0] {
        HFO_RUN = 2'h0,
        HFO_SUSP = 2'h1,
        HFO_SETTLE = 2'h3,
        HFO_OFF = 2'h2
    } hfo_state_e;

    // Special-function register access
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } hfo_sfr_s;

    // Wake sources
    typedef struct packed {
        logic port0_match;
        logic port1_match;
        logic timer3_ovf;
        logic cmp0_enabled;
        logic cmp0_out;
    } hfo_wake_s;

    // Divide ratio minus one for a divider code: 00->15, 01->7, 10->3, 11->1
    function automatic logic [3:0] hfo_div_last(input logic [1:0] code);
        hfo_div_last = 4'hf >> code;
    endfunction

endpackage

// >>> design/hfo_postdiv.sv
// Post-divider that turns the oscillator into a system clock enable pulse
`timescale 1ns/10ps
module hfo_postdiv (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic run_i,
    input wire logic bypass_i,
    input wire logic [1:0] div_code_i,
    output logic tick_o
);

    logic [3:0] cnt;
    logic [3:0] last;

    assign last = hfo_pkg::hfo_div_last(div_code_i);

    // Count oscillator cycles; the count clears to zero while stopped so no runt pulse appears
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            cnt <= 4'h0;
        end else if (!run_i || bypass_i || cnt >= last) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end

    // One pulse every ratio cycles, or every cycle when bypassed
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= run_i && (bypass_i || cnt >= last);
        end
    end

endmodule

// >>> design/hfo_ctrl.sv
// High-frequency oscillator control: registers, suspend and wake, ready and sync flags
`timescale 1ns/10ps
module hfo_ctrl #(
    parameter logic [6:0] TRIM_FACTORY = hfo_pkg::HFO_TRIM_RESET
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire hfo_pkg::hfo_sfr_s sfr_i,
    input wire logic [2:0] system_clock_source_select_i,
    input wire hfo_pkg::hfo_wake_s wake_i,
    input wire logic wake_timer_clk_i,
    output logic [7:0] sfr_rdata_o,
    output logic hf_osc_enable_o,
    output logic [6:0] hf_trim_o,
    output logic [1:0] hf_divide_select_o,
    output logic hf_freq_ready_o,
    output logic hf_suspended_o,
    output logic wake_timer_sync_busy_o,
    output logic core_clk_run_o,
    output logic system_clock_tick_o
);

    // Address hit for a write or read strobe
    function automatic logic sfr_hit(input hfo_pkg::hfo_sfr_s req, input logic [7:0] addr);
        sfr_hit = req.addr == addr;
    endfunction

    hfo_pkg::hfo_state_e state;
    hfo_pkg::hfo_state_e next_state;
    logic [2:0] src;
    logic suspend;
    logic [4:0] wake_meta;
    logic [4:0] wake_sync;
    logic [2:0] tclk_sync;
    logic [1:0] tclk_cnt;
    logic [3:0] settle_cnt;
    logic wake_any;
    logic wake_other;
    logic ctrl_wr;
    logic trim_wr;
    logic retune;
    logic src_is_hf;
    logic div_run;
    hfo_pkg::hfo_wake_s wk;

    assign ctrl_wr = sfr_i.wr && sfr_hit(sfr_i, hfo_pkg::HFO_CTRL_ADDR);
    assign trim_wr = sfr_i.wr && sfr_hit(sfr_i, hfo_pkg::HFO_TRIM_ADDR);

    // Wake sources come from other blocks and pins, possibly while our clock is gated
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_wake_sync
            always_ff @(posedge ref_clk_i) begin
                if (!nrst_i) begin
                    wake_meta[gi] <= 1'b0;
                    wake_sync[gi] <= 1'b0;
                end else begin
                    wake_meta[gi] <= wake_i[gi];
                    wake_sync[gi] <= wake_meta[gi];
                end
            end
        end
    endgenerate

    // Decode the synchronised wake sources
    assign wk = wake_sync;
    assign wake_any = wk.port0_match || wk.port1_match || wk.timer3_ovf
        || (wk.cmp0_enabled && !wk.cmp0_out);
    assign wake_other = wake_any && !wk.timer3_ovf;

    // Source select mirror; starts on the divided oscillator until the select is seen
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            src <= hfo_pkg::HFO_SRC_DIV;
        end else begin
            src <= system_clock_source_select_i;
        end
    end

    assign src_is_hf = src == hfo_pkg::HFO_SRC_DIV || src == hfo_pkg::HFO_SRC_DIRECT;

    // Enable bit, software owned
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            hf_osc_enable_o <= hfo_pkg::HFO_EN_RESET;
        end else if (ctrl_wr) begin
            hf_osc_enable_o <= sfr_i.wdata[hfo_pkg::HFO_EN_BIT];
        end
    end

    // Divider code; only the two low bits are stored
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            hf_divide_select_o <= hfo_pkg::HFO_DIV_RESET;
        end else if (ctrl_wr) begin
            hf_divide_select_o <= sfr_i.wdata[hfo_pkg::HFO_DIV_LSB +: 2];
        end
    end

    // Trim code drives the oscillator period; all ones is the slowest setting
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            hf_trim_o <= TRIM_FACTORY;
        end else if (trim_wr) begin
            hf_trim_o <= sfr_i.wdata[hfo_pkg::HFO_TRIM_LSB +: 7];
        end
    end

    // Suspend bit: a write of one sets it, a wake clears it; the write wins a tie
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            suspend <= 1'b0;
        end else if (ctrl_wr) begin
            suspend <= sfr_i.wdata[hfo_pkg::HFO_SUSP_BIT];
        end else if (state == hfo_pkg::HFO_SUSP && wake_any) begin
            suspend <= 1'b0;
        end
    end

    // Any change to the period or ratio means the output is off frequency for a while
    assign retune = (trim_wr && sfr_i.wdata[6:0] != hf_trim_o)
        || (ctrl_wr && sfr_i.wdata[1:0] != hf_divide_select_o);

    // Oscillator state
    always_comb begin
        next_state = state;
        case (state)
            hfo_pkg::HFO_RUN: begin
                if (!hf_osc_enable_o) begin
                    next_state = hfo_pkg::HFO_OFF;
                end else if (suspend) begin
                    next_state = hfo_pkg::HFO_SUSP;
                end else if (retune) begin
                    next_state = hfo_pkg::HFO_SETTLE;
                end
            end
            hfo_pkg::HFO_SUSP: begin
                if (wake_any) begin
                    next_state = hfo_pkg::HFO_SETTLE;
                end
            end
            hfo_pkg::HFO_SETTLE: begin
                if (!hf_osc_enable_o) begin
                    next_state = hfo_pkg::HFO_OFF;
                end else if (suspend) begin
                    next_state = hfo_pkg::HFO_SUSP;
                end else if (settle_cnt == 4'h0) begin
                    next_state = hfo_pkg::HFO_RUN;
                end
            end
            hfo_pkg::HFO_OFF: begin
                if (hf_osc_enable_o) begin
                    next_state = hfo_pkg::HFO_SETTLE;
                end
            end
            default: begin
                next_state = hfo_pkg::HFO_RUN;
            end
        endcase
    end

    // Running at the factory setting after reset, so ready starts high
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state <= hfo_pkg::HFO_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Settle timer reloads whenever the oscillator restarts, or retunes while running
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            settle_cnt <= 4'h0;
        end else if (next_state == hfo_pkg::HFO_SETTLE && state != hfo_pkg::HFO_SETTLE) begin
            settle_cnt <= 4'(hfo_pkg::HFO_SETTLE_CYC - 1);
        end else if (settle_cnt != 4'h0) begin
            settle_cnt <= settle_cnt - 4'h1;
        end
    end

    // Ready flag and visible suspend state
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            hf_freq_ready_o <= hfo_pkg::HFO_RDY_RESET;
            hf_suspended_o <= 1'b0;
        end else begin
            hf_freq_ready_o <= next_state == hfo_pkg::HFO_RUN;
            hf_suspended_o <= next_state == hfo_pkg::HFO_SUSP;
        end
    end

    // Core and peripheral clocks stop only when this oscillator feeds them. The core
    // holds its state, so it continues after the suspending write once clocks return.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            core_clk_run_o <= 1'b1;
        end else begin
            core_clk_run_o <= !(src_is_hf && next_state == hfo_pkg::HFO_SUSP);
        end
    end

    // Divider follows the next state, so no pulse slips out as suspend begins; 011 bypasses it
    assign div_run = next_state == hfo_pkg::HFO_RUN || next_state == hfo_pkg::HFO_SETTLE;

    hfo_postdiv u_postdiv (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .run_i(div_run && src_is_hf),
        .bypass_i(src == hfo_pkg::HFO_SRC_DIRECT),
        .div_code_i(hf_divide_select_o),
        .tick_o(system_clock_tick_o)
    );

    // Wake timer clock is foreign; a third stage only serves edge detection
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            tclk_sync <= 3'h0;
        end else begin
            tclk_sync <= {tclk_sync[1:0], wake_timer_clk_i};
        end
    end

    // Sync busy: the timer needs a few of its own clocks to catch up after a foreign wake
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            wake_timer_sync_busy_o <= 1'b0;
            tclk_cnt <= 2'h0;
        end else if (state == hfo_pkg::HFO_SUSP && wake_other) begin
            wake_timer_sync_busy_o <= 1'b1;
            tclk_cnt <= 2'(hfo_pkg::HFO_SYNC_TIMER_CLKS);
        end else if (wake_timer_sync_busy_o && tclk_sync[1] && !tclk_sync[2]) begin
            tclk_cnt <= tclk_cnt - 2'h1;
            wake_timer_sync_busy_o <= tclk_cnt != 2'h1;
        end
    end

    // Read port: registered, unused bits zero, unmapped addresses read zero
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_i.rd && sfr_hit(sfr_i, hfo_pkg::HFO_CTRL_ADDR)) begin
            sfr_rdata_o <= {hf_osc_enable_o, hf_freq_ready_o, suspend,
                wake_timer_sync_busy_o, 2'h0, hf_divide_select_o};
        end else if (sfr_i.rd && sfr_hit(sfr_i, hfo_pkg::HFO_TRIM_ADDR)) begin
            sfr_rdata_o <= {1'b0, hf_trim_o};
        end else begin
            sfr_rdata_o <= 8'h00;
        end
    end

    // Checks

    property p_div_reset;
        @(posedge ref_clk_i) !nrst_i |=> hf_divide_select_o == 2'h0 && hf_osc_enable_o;
    endproperty
    a_div_reset: assert property (p_div_reset) else $error("divider or enable wrong after reset");

    property p_ready_reset;
        @(posedge ref_clk_i) !nrst_i ##1 nrst_i |-> hf_freq_ready_o && !hf_suspended_o;
    endproperty
    a_ready_reset: assert property (p_ready_reset) else $error("ready low after reset");

    property p_suspend_write;
        @(posedge ref_clk_i) disable iff (!nrst_i)
            ctrl_wr && sfr_i.wdata[5] && hf_osc_enable_o && state == hfo_pkg::HFO_RUN
            |=> ##1 hf_suspended_o || wake_any;
    endproperty
    a_suspend_write: assert property (p_suspend_write) else $error("suspend not entered");

    property p_core_gate;
        @(posedge ref_clk_i) disable iff (!nrst_i)
            hf_suspended_o && src_is_hf |-> !core_clk_run_o && !system_clock_tick_o;
    endproperty
    a_core_gate: assert property (p_core_gate) else $error("core clock runs in suspend");

    property p_wake_clears;
        @(posedge ref_clk_i) disable iff (!nrst_i)
            state == hfo_pkg::HFO_SUSP && wake_any && !ctrl_wr
            |=> !suspend && state == hfo_pkg::HFO_SETTLE ##1 core_clk_run_o;
    endproperty
    a_wake_clears: assert property (p_wake_clears) else $error("wake did not resume");

    property p_busy_set;
        @(posedge ref_clk_i) disable iff (!nrst_i)
            state == hfo_pkg::HFO_SUSP && wake_other |=> wake_timer_sync_busy_o;
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("sync busy not raised");

    property p_unused_zero;
        @(posedge ref_clk_i) disable iff (!nrst_i)
            sfr_i.rd |=> sfr_rdata_o[3:2] == 2'h0 || $past(sfr_i.addr) != 8'hb2;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");

    property p_bypass_tick;
        @(posedge ref_clk_i) disable iff (!nrst_i)
            next_state == hfo_pkg::HFO_RUN && src == hfo_pkg::HFO_SRC_DIRECT |=> system_clock_tick_o;
    endproperty
    a_bypass_tick: assert property (p_bypass_tick) else $error("undivided clock missing");

    property p_div16_spacing;
        @(posedge ref_clk_i) disable iff (!nrst_i)
            system_clock_tick_o && src == hfo_pkg::HFO_SRC_DIV && hf_divide_select_o == 2'h0
            && $stable(src) |=> (!system_clock_tick_o || hf_divide_select_o != 2'h0) [*8];
    endproperty
    a_div16_spacing: assert property (p_div16_spacing) else $error("divide by 16 too fast");

endmodule

// >>> verification/test_hfo_ctrl.sv
// Register-level testbench for the high-frequency oscillator control block
`timescale 1ns/10ps
module test_hfo_ctrl;
    logic ref_clk;
    logic nrst;
    hfo_pkg::hfo_sfr_s sfr;
    logic [2:0] src_sel;
    hfo_pkg::hfo_wake_s wake;
    logic wt_clk;
    logic [7:0] rdata;
    logic osc_en;
    logic [6:0] trim;
    logic [1:0] div_sel;
    logic ready;
    logic susp;
    logic sync_busy;
    logic core_run;
    logic tick;
    int fails = 0;
    int cmp_count = 0;
    int gap;
    logic [7:0] got;
    logic exp_busy;

    hfo_ctrl uut (
        .ref_clk_i(ref_clk),
        .nrst_i(nrst),
        .sfr_i(sfr),
        .system_clock_source_select_i(src_sel),
        .wake_i(wake),
        .wake_timer_clk_i(wt_clk),
        .sfr_rdata_o(rdata),
        .hf_osc_enable_o(osc_en),
        .hf_trim_o(trim),
        .hf_divide_select_o(div_sel),
        .hf_freq_ready_o(ready),
        .hf_suspended_o(susp),
        .wake_timer_sync_busy_o(sync_busy),
        .core_clk_run_o(core_run),
        .system_clock_tick_o(tick)
    );

    // Free-running 20 MHz reference
    always #25 ref_clk = ~ref_clk;

    task automatic final_report();
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Single-cycle strobes; the next access starts on a later edge
    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        sfr.addr <= addr;
        sfr.wdata <= data;
        sfr.wr <= 1'b1;
        @(posedge ref_clk);
        sfr.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe is taken
    task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge ref_clk);
        sfr.addr <= addr;
        sfr.rd <= 1'b1;
        @(posedge ref_clk);
        sfr.rd <= 1'b0;
        #1;
        data = rdata;
    endtask

    // Bounded wait for a flag: 0 ready, 1 suspended, 2 sync busy
    task automatic wait_for(input int which, input logic val, input int bound);
        int n;
        logic f;
        n = 0;
        f = ~val;
        while (f !== val && n < bound) begin
            @(posedge ref_clk);
            #1;
            n++;
            f = (which == 0) ? ready : (which == 1) ? susp : sync_busy;
        end
        if (f !== val) begin
            fails++;
            $display("ERROR %0t: flag %0d wait ran out", $time, which);
            final_report();
        end
    endtask

    // Cycles between two system clock enable pulses, zero if none seen
    task automatic measure_gap(output int g);
        int n;
        n = 0;
        g = 0;
        while (tick !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (tick === 1'b1) begin
            @(posedge ref_clk);
            #1;
            g = 1;
            while (tick !== 1'b1 && g < 40) begin
                @(posedge ref_clk);
                #1;
                g++;
            end
        end
    endtask

    // Wake timer clock edges spaced well above the synchroniser minimum
    task automatic pulse_wt_clk(input int n);
        repeat (n) begin
            repeat (3) @(posedge ref_clk);
            wt_clk <= 1'b1;
            repeat (3) @(posedge ref_clk);
            wt_clk <= 1'b0;
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        sfr = '0;
        src_sel = 3'h0;
        wake = '0;
        wake.cmp0_out = 1'b1;
        wt_clk = 1'b0;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        // Reset values, reads one idle cycle apart, unmapped address
        sfr_read(hfo_pkg::HFO_CTRL_ADDR, got);
        check(got, 8'hc0);
        sfr_read(hfo_pkg::HFO_TRIM_ADDR, got);
        check(got, {1'b0, hfo_pkg::HFO_TRIM_RESET});
        sfr_read(8'hb4, got);
        check(got, 8'h00);
        measure_gap(gap);
        check(8'(gap), 8'h10);
        // Trim field: all ones, bit 7 ignored, ready drops on retune
        sfr_write(hfo_pkg::HFO_TRIM_ADDR, 8'hff);
        #1;
        check({1'b0, trim}, {1'b0, hfo_pkg::HFO_TRIM_SLOWEST});
        check({7'h0, ready}, 8'h00);
        wait_for(0, 1'b1, 40);
        sfr_read(hfo_pkg::HFO_TRIM_ADDR, got);
        check(got, 8'h7f);
        // Read-only and unused control bits ignore writes
        sfr_write(hfo_pkg::HFO_CTRL_ADDR, 8'h9e);
        wait_for(0, 1'b1, 40);
        sfr_read(hfo_pkg::HFO_CTRL_ADDR, got);
        check(got, 8'hc2);
        // Every divider code through the divided path
        for (int c = 0; c < 4; c++) begin
            sfr_write(hfo_pkg::HFO_CTRL_ADDR, 8'h80 | 8'(c));
            wait_for(0, 1'b1, 40);
            check({6'h0, div_sel}, 8'(c));
            measure_gap(gap);
            check(8'(gap), 8'(16 >> c));
        end
        // Undivided path ignores the divider; other sources give no pulses
        @(posedge ref_clk);
        src_sel <= hfo_pkg::HFO_SRC_DIRECT;
        repeat (4) @(posedge ref_clk);
        measure_gap(gap);
        check(8'(gap), 8'h01);
        @(posedge ref_clk);
        src_sel <= 3'h1;
        repeat (4) @(posedge ref_clk);
        measure_gap(gap);
        check(8'(gap), 8'h00);
        // Suspend under another source keeps the core clock running
        sfr_write(hfo_pkg::HFO_CTRL_ADDR, 8'ha0);
        wait_for(1, 1'b1, 5);
        check({7'h0, core_run}, 8'h01);
        @(posedge ref_clk);
        wake.port0_match <= 1'b1;
        wait_for(1, 1'b0, 10);
        @(posedge ref_clk);
        wake.port0_match <= 1'b0;
        pulse_wt_clk(3);
        wait_for(2, 1'b0, 10);
        @(posedge ref_clk);
        src_sel <= hfo_pkg::HFO_SRC_DIV;
        // Enable bit
        sfr_write(hfo_pkg::HFO_CTRL_ADDR, 8'h00);
        #1;
        check({7'h0, osc_en}, 8'h00);
        sfr_read(hfo_pkg::HFO_CTRL_ADDR, got);
        check(got, 8'h00);
        sfr_write(hfo_pkg::HFO_CTRL_ADDR, 8'h80);
        wait_for(0, 1'b1, 40);
        // Suspend and wake from each source in turn
        for (int s = 0; s < 4; s++) begin
            sfr_write(hfo_pkg::HFO_CTRL_ADDR, 8'ha0);
            wait_for(1, 1'b1, 5);
            repeat (2) @(posedge ref_clk);
            #1;
            check({6'h0, core_run, ready}, 8'h00);
            sfr_read(hfo_pkg::HFO_CTRL_ADDR, got);
            check(got, 8'ha0);
            exp_busy = (s != 2);
            @(posedge ref_clk);
            if (s == 3) begin
                // Enabled comparator with a high output must not wake
                wake.cmp0_enabled <= 1'b1;
                repeat (8) @(posedge ref_clk);
                #1;
                check({7'h0, susp}, 8'h01);
                @(posedge ref_clk);
                wake.cmp0_out <= 1'b0;
            end else if (s == 2) begin
                wake.timer3_ovf <= 1'b1;
            end else if (s == 1) begin
                wake.port1_match <= 1'b1;
            end else begin
                wake.port0_match <= 1'b1;
            end
            wait_for(1, 1'b0, 10);
            check({6'h0, core_run, sync_busy}, {6'h0, 1'b1, exp_busy});
            @(posedge ref_clk);
            wake <= 5'h01; // All sources quiet, comparator output idles high
            wait_for(0, 1'b1, 40);
            sfr_read(hfo_pkg::HFO_CTRL_ADDR, got);
            check(got, {3'h6, exp_busy, 4'h0});
            pulse_wt_clk(3);
            repeat (4) @(posedge ref_clk);
            #1;
            check({7'h0, sync_busy}, 8'h00);
            measure_gap(gap);
            check(8'(gap), 8'h10);
        end
        final_report();
    end
endmodule
